// [design/rhm_top.sv]
// register bank and monitor for reference validation and holdover averaging
// assumes an apb master on ref_clk_i; loop status inputs synchronous to it
`default_nettype none
module rhm_top
	import rhm_pkg::*;
#(
	parameter int FTW_W = RHM_FTW_W,
	parameter int OOL_DIV_W = 16
) (
	input wire logic ref_clk_i, // 250 MHz clock
	input wire logic rst_b_i, // async reset, active low
	input wire logic psel, // apb select
	input wire logic penable, // apb enable
	input wire logic pwrite, // apb direction
	input wire logic [13:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error
	input wire logic [FTW_W-1:0] frequency_tuning_word_i, // live loop tuning word
	input wire logic holdover_i, // loop in holdover
	input wire logic ref_b_active_i, // reference b drives loop
	input wire logic est_too_high_i, // estimator: frequency too high
	input wire logic est_too_low_i, // estimator: frequency too low
	input wire logic est_done_i, // estimator finished
	input wire logic [15:0] phase_adj_i, // phase adjustment magnitude
	input wire logic [15:0] edge_diff_i, // abs diff of consecutive detector edges
	input wire logic edge_stb_i, // new edge difference
	input wire logic ref_a_edge_i, // reference a input clock edge strobe
	input wire logic ref_b_edge_i, // reference b input clock edge strobe
	input wire logic ref_a_loss_i, // reference_loss_event a level
	input wire logic ref_b_loss_i, // reference_loss_event b level
	input wire logic ref_a_ool_i, // out_of_limits_event a level
	input wire logic ref_b_ool_i, // out_of_limits_event b level
	output logic [FTW_W-1:0] holdover_ftw_o, // tuning word for holdover
	output logic ref_a_valid_o, // reference a usable by loop
	output logic ref_b_valid_o, // reference b usable by loop
	output logic ool_eval_a_o, // reference a ool evaluation tick
	output logic ool_eval_b_o // reference b ool evaluation tick
);
	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	logic [7:0] avg_window_r;
	logic [7:0] valid_time_r;
	logic [7:0] auto_ctrl_r;
	logic [RHM_PRESC_W-1:0] presc_r;
	logic [15:0] plock_thr_r;
	logic [15:0] flock_thr_r;
	logic [OOL_DIV_W-1:0] ool_div_r;
	logic [7:0] status;
	logic [11:0] idx;
	logic wr_en;
	logic rd_en;
	logic mapped;
	logic [31:0] rdata_nxt;

	assign idx = paddr[13:2];
	assign wr_en = psel && penable && pwrite;
	assign rd_en = psel && !penable && !pwrite;
	always_comb begin
		mapped = 1'b1;
		case (idx)
			RHM_IDX_AVG_WINDOW, RHM_IDX_VALID_TIME, RHM_IDX_LOOP_STATUS,
			RHM_IDX_AUTO_CTRL, RHM_IDX_LOOP_CTRL, RHM_IDX_REF_STATE: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	end

	// single-cycle access phase: ready always high, errors for unmapped or status writes
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			pready <= 1'b1;
			pslverr <= 1'b0;
		end else begin
			pready <= 1'b1;
			if (psel && !penable)
				pslverr <= !mapped || (pwrite && idx == RHM_IDX_LOOP_STATUS);
			else if (!psel)
				pslverr <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			avg_window_r <= RHM_AVG_WINDOW_RST;
			valid_time_r <= RHM_VALID_TIME_RST;
			auto_ctrl_r <= RHM_AUTO_CTRL_RST;
		end else if (wr_en) begin
			case (idx)
				RHM_IDX_AVG_WINDOW: avg_window_r <= {4'h0, pwdata[3:0]};
				RHM_IDX_VALID_TIME: valid_time_r <= {3'h0, pwdata[4:0]};
				RHM_IDX_AUTO_CTRL: auto_ctrl_r <= {3'h0, pwdata[4:0]};
				default: ;
			endcase
		end
	end

	// loop control word: prescaler, lock thresholds; ool divider from the reference state word
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			presc_r <= '0;
			plock_thr_r <= 16'h0000;
			flock_thr_r <= 16'h0000;
			ool_div_r <= OOL_DIV_W'(1);
		end else if (wr_en) begin
			if (idx == RHM_IDX_LOOP_CTRL) begin
				presc_r <= pwdata[3:0];
				plock_thr_r <= {4'h0, pwdata[15:4]};
				flock_thr_r <= {pwdata[31:16]};
			end else if (idx == RHM_IDX_REF_STATE) begin
				ool_div_r <= OOL_DIV_W'(pwdata[31:16]);
			end
		end
	end

	// ---------------------------------------------------------------
	// read path
	// ---------------------------------------------------------------
	always_comb begin
		rdata_nxt = 32'h0000_0000;
		case (idx)
			RHM_IDX_AVG_WINDOW: rdata_nxt = {24'h00_0000, avg_window_r};
			RHM_IDX_VALID_TIME: rdata_nxt = {24'h00_0000, valid_time_r};
			RHM_IDX_AUTO_CTRL: rdata_nxt = {24'h00_0000, auto_ctrl_r};
			RHM_IDX_LOOP_STATUS: rdata_nxt = {24'h00_0000, status};
			RHM_IDX_LOOP_CTRL: rdata_nxt = {flock_thr_r, plock_thr_r[11:0], presc_r};
			RHM_IDX_REF_STATE: rdata_nxt = {16'(ool_div_r), 14'h0000,
				ref_b_valid_o, ref_a_valid_o};
			default: rdata_nxt = 32'h0000_0000;
		endcase
	end

	// read data captured at setup, so the live value is at most one cycle old
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i)
			prdata <= 32'h0000_0000;
		else if (rd_en)
			prdata <= rdata_nxt;
	end

	// ---------------------------------------------------------------
	// lock detectors
	// ---------------------------------------------------------------
	logic plock_r;
	logic flock_r;
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i)
			plock_r <= 1'b0;
		else
			plock_r <= (phase_adj_i <= plock_thr_r);
	end
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i)
			flock_r <= 1'b0;
		else if (edge_stb_i)
			flock_r <= (edge_diff_i <= flock_thr_r);
	end

	// live status: no latching, lock bits registered from the comparisons, other bits follow the inputs directly
	assign status = {1'b0, est_too_high_i,
		est_too_low_i,
		est_done_i,
		ref_b_active_i,
		holdover_i,
		plock_r, flock_r}; // phase lock may read set in holdover

	// ---------------------------------------------------------------
	// sample and loop filter clock divider, one counter for both
	// ---------------------------------------------------------------
	logic [15:0] presc_cnt_r;
	logic loop_tick_r;
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			presc_cnt_r <= 16'h0000;
			loop_tick_r <= 1'b0;
		end else begin
			loop_tick_r <= 1'b0;
			if (presc_cnt_r >= (16'(1) << presc_r) - 16'(1)) begin
				presc_cnt_r <= 16'h0000;
				loop_tick_r <= 1'b1;
			end else begin
				presc_cnt_r <= presc_cnt_r + 16'(1);
			end
		end
	end

	// ool evaluation: one tick every divider count of reference edges
	logic [OOL_DIV_W-1:0] ool_cnt_a_r;
	logic [OOL_DIV_W-1:0] ool_cnt_b_r;
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ool_cnt_a_r <= '0;
			ool_cnt_b_r <= '0;
			ool_eval_a_o <= 1'b0;
			ool_eval_b_o <= 1'b0;
		end else begin
			ool_eval_a_o <= 1'b0;
			ool_eval_b_o <= 1'b0;
			if (ref_a_edge_i) begin
				if (ool_cnt_a_r + OOL_DIV_W'(1) >= ool_div_r) begin
					ool_cnt_a_r <= '0;
					ool_eval_a_o <= 1'b1;
				end else
					ool_cnt_a_r <= ool_cnt_a_r + OOL_DIV_W'(1);
			end
			if (ref_b_edge_i) begin
				if (ool_cnt_b_r + OOL_DIV_W'(1) >= ool_div_r) begin
					ool_cnt_b_r <= '0;
					ool_eval_b_o <= 1'b1;
				end else
					ool_cnt_b_r <= ool_cnt_b_r + OOL_DIV_W'(1);
			end
		end
	end

	// ---------------------------------------------------------------
	// reference validation
	// ---------------------------------------------------------------
	rhm_ref_valid u_valid_a (
		.ref_clk_i(ref_clk_i),
		.rst_b_i(rst_b_i),
		.loop_tick_i(loop_tick_r),
		.fault_i(ref_a_loss_i || ref_a_ool_i),
		.timer_i(valid_time_r[4:0]),
		.valid_o(ref_a_valid_o)
	);
	rhm_ref_valid u_valid_b (
		.ref_clk_i(ref_clk_i),
		.rst_b_i(rst_b_i),
		.loop_tick_i(loop_tick_r),
		.fault_i(ref_b_loss_i || ref_b_ool_i),
		.timer_i(valid_time_r[4:0]),
		.valid_o(ref_b_valid_o)
	);

	// ---------------------------------------------------------------
	// holdover tuning word
	// ---------------------------------------------------------------
	logic [FTW_W-1:0] avg_ftw;
	logic hold_d_r;
	rhm_ftw_avg #(.FTW_W(FTW_W), .MAX_LOG2(RHM_MAX_LOG2)) u_avg (
		.ref_clk_i(ref_clk_i),
		.rst_b_i(rst_b_i),
		.enable_i(auto_ctrl_r[RHM_AUTO_AVG_BIT]),
		.sample_en_i(loop_tick_r && !holdover_i),
		.log2_size_i(avg_window_r[3:0]),
		.ftw_i(frequency_tuning_word_i),
		.avg_o(avg_ftw)
	);

	// freeze the word at holdover entry; track the live word otherwise
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			hold_d_r <= 1'b0;
			holdover_ftw_o <= '0;
		end else begin
			hold_d_r <= holdover_i;
			if (!holdover_i)
				holdover_ftw_o <= frequency_tuning_word_i;
			else if (!hold_d_r)
				holdover_ftw_o <= auto_ctrl_r[RHM_AUTO_AVG_BIT] ? avg_ftw
					: holdover_ftw_o;
		end
	end
endmodule
`default_nettype wire

// [design/rhm_pkg.sv]
// package for the reference holdover monitor: offsets, fields, reset values
// assumes a 32-bit apb slave at 250 MHz with one aligned word per register
//
// How it works
// - average window is two to the field
// - averaging active only with averaged-holdover bit
// - samples taken at fs over two to prescaler
// - reference withheld until validation time elapses
// - validation lasts loop period times 2^(n+1)-1
// - out-of-limits period is ref period times divider
// - status read-only, live, never latched
// - bit 6 means estimator saw frequency too high
// - bit 5 means estimator saw frequency too low
// - bit 4 means estimator finished successfully
// - bit 3 shows active reference, b is one
// - bit 2 set while loop is in holdover
// - bit 1 phase lock against threshold
// - bit 0 frequency lock against threshold
// - phase and frequency lock independent
// - holdover uses last or averaged tuning word
`default_nettype none
package rhm_pkg;
	// printed offsets are not all multiples of four: they are indices, address is index*4
	localparam logic [11:0] RHM_IDX_AVG_WINDOW = 12'h01c2;
	localparam logic [11:0] RHM_IDX_VALID_TIME = 12'h01c3;
	localparam logic [11:0] RHM_IDX_LOOP_STATUS = 12'h0300;
	localparam logic [11:0] RHM_IDX_AUTO_CTRL = 12'h01c0;
	localparam logic [11:0] RHM_IDX_LOOP_CTRL = 12'h0400;
	localparam logic [11:0] RHM_IDX_REF_STATE = 12'h0401;
	localparam int RHM_AVG_SIZE_LSB = 0;
	localparam int RHM_AVG_SIZE_W = 4;
	localparam int RHM_VAL_TIMER_W = 5;
	localparam int RHM_AUTO_AVG_BIT = 4;
	localparam int RHM_ST_HIGH = 6;
	localparam int RHM_ST_LOW = 5;
	localparam int RHM_ST_DONE = 4;
	localparam int RHM_ST_REFSEL = 3;
	localparam int RHM_ST_FREERUN = 2;
	localparam int RHM_ST_PLOCK = 1;
	localparam int RHM_ST_FLOCK = 0;
	localparam logic [7:0] RHM_AVG_WINDOW_RST = 8'h0f;
	localparam logic [7:0] RHM_VALID_TIME_RST = 8'h00;
	localparam logic [7:0] RHM_AUTO_CTRL_RST = 8'h00;
	localparam logic [7:0] RHM_LOOP_CTRL_RST = 8'h00;
	localparam int RHM_FTW_W = 48;
	localparam int RHM_PRESC_W = 4;
	localparam int RHM_MAX_LOG2 = 15;
	typedef enum logic [1:0] {
		RHM_REF_VALID,
		RHM_REF_WAIT,
		RHM_REF_TIMING
	} rhm_ref_type;
endpackage
`default_nettype wire

// [design/rhm_ftw_avg.sv]
// windowed block mean of tuning-word samples
// assumes sample_en_i is a one-cycle pulse at the decimated sample rate
`default_nettype none
module rhm_ftw_avg
	import rhm_pkg::*;
#(
	parameter int FTW_W = RHM_FTW_W,
	parameter int MAX_LOG2 = RHM_MAX_LOG2
) (
	input wire logic ref_clk_i, // clock
	input wire logic rst_b_i, // async reset, active low
	input wire logic enable_i, // averaging switched on
	input wire logic sample_en_i, // decimated sample strobe
	input wire logic [3:0] log2_size_i, // window is 2^n samples
	input wire logic [FTW_W-1:0] ftw_i, // live tuning word
	output logic [FTW_W-1:0] avg_o // averaged tuning word
);
	localparam int ACC_W = FTW_W + MAX_LOG2 + 1;
	logic [ACC_W-1:0] acc_r;
	logic [MAX_LOG2:0] cnt_r;
	logic [MAX_LOG2:0] win;
	logic [3:0] size_c;

	// sizes above the maximum clamp; block average, refreshed each full window
	assign size_c = (log2_size_i > 4'(MAX_LOG2)) ? 4'(MAX_LOG2) : log2_size_i;
	assign win = (MAX_LOG2+1)'(1) << size_c;

	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			acc_r <= '0;
			cnt_r <= '0;
			avg_o <= '0;
		end else if (!enable_i) begin
			acc_r <= '0;
			cnt_r <= '0;
			avg_o <= ftw_i;
		end else if (sample_en_i) begin
			if (cnt_r + (MAX_LOG2+1)'(1) >= win) begin
				avg_o <= FTW_W'((acc_r + ACC_W'(ftw_i)) >> size_c);
				acc_r <= '0;
				cnt_r <= '0;
			end else begin
				acc_r <= acc_r + ACC_W'(ftw_i);
				cnt_r <= cnt_r + (MAX_LOG2+1)'(1);
			end
		end
	end
endmodule
`default_nettype wire

// [design/rhm_ref_valid.sv]
// validation timer for one reference after loss or out-of-limits
// assumes loop_tick_i is the loop filter clock as a one-cycle enable
`default_nettype none
module rhm_ref_valid
	import rhm_pkg::*;
(
	input wire logic ref_clk_i, // clock
	input wire logic rst_b_i, // async reset, active low
	input wire logic loop_tick_i, // loop filter clock enable
	input wire logic fault_i, // loss or out-of-limits level
	input wire logic [RHM_VAL_TIMER_W-1:0] timer_i, // validation field
	output logic valid_o // reference usable
);
	logic [32:0] cnt_r;
	logic [32:0] target;
	rhm_ref_type st_r;

	// 2^(n+1)-1 loop periods
	assign target = (33'(1) << (6'(timer_i) + 6'd1)) - 33'(1);

	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			st_r <= RHM_REF_WAIT;
			cnt_r <= '0;
			valid_o <= 1'b0;
		end else begin
			case (st_r)
				RHM_REF_VALID: begin
					if (fault_i) begin
						st_r <= RHM_REF_WAIT;
						valid_o <= 1'b0;
					end
				end
				RHM_REF_WAIT: begin
					cnt_r <= '0;
					if (!fault_i)
						st_r <= RHM_REF_TIMING;
				end
				RHM_REF_TIMING: begin
					if (fault_i) begin
						st_r <= RHM_REF_WAIT;
					end else if (loop_tick_i) begin
						if (cnt_r + 33'(1) >= target) begin
							st_r <= RHM_REF_VALID;
							valid_o <= 1'b1;
						end
						cnt_r <= cnt_r + 33'(1);
					end
				end
				default: st_r <= RHM_REF_WAIT;
			endcase
		end
	end
endmodule
`default_nettype wire

// [sim/rhm_top_sva.sv]
// checker for the holdover monitor register bank: apb answers and monitor outputs
// assumes it is bound onto rhm_top and sees nothing but its ports
`default_nettype none
module rhm_top_chk
	import rhm_pkg::*;
#(
	parameter int FTW_W = RHM_FTW_W
) (
	input wire logic ref_clk_i, // clock
	input wire logic rst_b_i, // reset, active low
	input wire logic psel, // apb select
	input wire logic penable, // apb enable
	input wire logic pwrite, // apb direction
	input wire logic [13:0] paddr, // apb address
	input wire logic [31:0] prdata, // read data
	input wire logic pready, // ready
	input wire logic pslverr, // error
	input wire logic holdover_i, // free run
	input wire logic ref_b_active_i, // b drives loop
	input wire logic est_too_high_i, // estimator high
	input wire logic est_too_low_i, // estimator low
	input wire logic est_done_i, // estimator done
	input wire logic ref_a_edge_i, // a edge strobe
	input wire logic ref_a_loss_i, // a loss
	input wire logic ref_b_loss_i, // b loss
	input wire logic ref_a_ool_i, // a out of limits
	input wire logic ref_b_ool_i, // b out of limits
	input wire logic [FTW_W-1:0] holdover_ftw_o, // holdover word
	input wire logic ref_a_valid_o, // a usable
	input wire logic ref_b_valid_o, // b usable
	input wire logic ool_eval_a_o // a evaluation tick
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [13:0] ST_ADDR = {RHM_IDX_LOOP_STATUS, 2'b00};
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!rst_b_i);
	logic acc;
	logic st_rd;
	logic [4:0] st_now;
	assign acc = psel && penable;
	assign st_rd = acc && !pwrite && paddr == ST_ADDR;
	assign st_now = {est_too_high_i, est_too_low_i, est_done_i, ref_b_active_i, holdover_i};
	// status may lag its inputs by one cycle, so either of the last two samples counts
	AST_NO_WAIT: assert property (acc |-> pready)
		else $error("access phase without ready");
	AST_ST_WRITE_ERR: assert property (acc && pwrite && paddr == ST_ADDR |-> pslverr)
		else $error("status write not refused");
	AST_ST_RSVD: assert property (st_rd |-> prdata[31:7] == '0 && !pslverr)
		else $error("status upper bits or error wrong");
	AST_ST_EST: assert property (st_rd |-> prdata[6:4] == $past(st_now[4:2]) ||
			prdata[6:4] == $past(st_now[4:2], 2))
		else $error("estimator status bits not live");
	AST_ST_REF: assert property (st_rd |-> prdata[3:2] == $past(st_now[1:0]) ||
			prdata[3:2] == $past(st_now[1:0], 2))
		else $error("reference or free run bit not live");
	AST_A_WITHHELD: assert property (ref_a_loss_i || ref_a_ool_i |=> !ref_a_valid_o)
		else $error("faulty reference a still usable");
	AST_B_WITHHELD: assert property (ref_b_loss_i || ref_b_ool_i |=> !ref_b_valid_o)
		else $error("faulty reference b still usable");
	AST_A_RISE: assert property ($rose(ref_a_valid_o) |->
			!$past(ref_a_loss_i || ref_a_ool_i))
		else $error("reference a validated while faulty");
	AST_OOL_TICK: assert property (ool_eval_a_o |->
			$past(ref_a_edge_i) || $past(ref_a_edge_i, 2))
		else $error("evaluation tick without reference edge");
	AST_HOLD_FROZEN: assert property (holdover_i && $past(holdover_i) &&
			$past(holdover_i, 2) && $past(holdover_i, 3) |-> $stable(holdover_ftw_o))
		else $error("holdover word moved during holdover");
	cover property (acc && pwrite && paddr == ST_ADDR);
	cover property ($rose(ref_a_valid_o));
	cover property (ool_eval_a_o);
	cover property ($rose(holdover_i));
endmodule
bind rhm_top rhm_top_chk #(.FTW_W(FTW_W)) u_chk (
	.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .holdover_i(holdover_i),
	.ref_b_active_i(ref_b_active_i), .est_too_high_i(est_too_high_i),
	.est_too_low_i(est_too_low_i), .est_done_i(est_done_i), .ref_a_edge_i(ref_a_edge_i),
	.ref_a_loss_i(ref_a_loss_i), .ref_b_loss_i(ref_b_loss_i), .ref_a_ool_i(ref_a_ool_i),
	.ref_b_ool_i(ref_b_ool_i), .holdover_ftw_o(holdover_ftw_o), .ref_a_valid_o(ref_a_valid_o),
	.ref_b_valid_o(ref_b_valid_o), .ool_eval_a_o(ool_eval_a_o)
);
`default_nettype wire

// [sim/rhm_top_bench.sv]
// self-checking bench for the holdover monitor register bank
// assumes rhm_top answers apb with no wait states; all monitor inputs driven here
`default_nettype none
module rhm_top_bench
	import rhm_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk_i = 0, rst_b_i = 0, psel = 0, penable = 0, pwrite = 0;
	logic [13:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd;
	logic pready, pslverr, er, va, vb, eva, evb;
	logic [47:0] ftw = '0, hftw;
	logic [4:0] stv = '0;
	logic estb = 0, ea = 0, eb = 0, la = 0, lb = 0, oa = 0, ob = 0;
	logic [15:0] padj = '0, ediff = '0;
	int n_fail = 0, total_checks = 0, cyc = 0, nev = 0, nevb = 0, k, n0, xp;
	always #2 ref_clk_i = ~ref_clk_i;
	rhm_top u_dut (
		.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .frequency_tuning_word_i(ftw), .holdover_i(stv[0]),
		.ref_b_active_i(stv[1]), .est_done_i(stv[2]), .est_too_low_i(stv[3]),
		.est_too_high_i(stv[4]), .phase_adj_i(padj), .edge_diff_i(ediff), .edge_stb_i(estb),
		.ref_a_edge_i(ea), .ref_b_edge_i(eb), .ref_a_loss_i(la), .ref_b_loss_i(lb),
		.ref_a_ool_i(oa), .ref_b_ool_i(ob), .holdover_ftw_o(hftw), .ref_a_valid_o(va),
		.ref_b_valid_o(vb), .ool_eval_a_o(eva), .ool_eval_b_o(evb)
	);
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic finish_test();
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	always @(posedge ref_clk_i) begin
		cyc <= cyc + 1;
		if (eva === 1'b1) begin
			nev <= nev + 1;
		end
		if (evb === 1'b1) begin
			nevb <= nevb + 1;
		end
		if (cyc == 5000) begin
			n_fail = n_fail + 1;
			finish_test();
		end
	end
	task automatic chk(input logic [47:0] got, input logic [47:0] exp, input string what);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	// values taken in the active region after the edge, before the slave updates
	task automatic xfer(input logic w, input logic [11:0] idx, input logic [31:0] wd);
		@(posedge ref_clk_i);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {idx, 2'b00};
		pwdata <= wd;
		@(posedge ref_clk_i);
		penable <= 1'b1;
		@(posedge ref_clk_i);
		while (pready !== 1'b1) @(posedge ref_clk_i);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rchk(input logic [11:0] idx, input logic [31:0] exp, input logic eexp,
			input string what);
		xfer(1'b0, idx, 32'h0000_0000);
		chk(48'(rd), 48'(exp), what);
		chk(48'(er), 48'(eexp), what);
	endtask
	task automatic edge_diff(input logic [15:0] pa, input logic [15:0] ed);
		padj <= pa;
		ediff <= ed;
		estb <= 1'b1;
		@(posedge ref_clk_i);
		estb <= 1'b0;
		repeat (3) @(posedge ref_clk_i);
	endtask
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		repeat (2) @(posedge ref_clk_i);
		rst_b_i <= 1'b1;
		rchk(RHM_IDX_AVG_WINDOW, 32'h0000_000f, 1'b0, "window reset");
		rchk(RHM_IDX_VALID_TIME, 32'h0000_0000, 1'b0, "timer reset");
		rchk(RHM_IDX_AUTO_CTRL, 32'h0000_0000, 1'b0, "auto reset");
		xfer(1'b1, RHM_IDX_AVG_WINDOW, 32'h0000_000a);
		rchk(RHM_IDX_AVG_WINDOW, 32'h0000_000a, 1'b0, "window rw");
		xfer(1'b1, RHM_IDX_LOOP_STATUS, 32'h0000_00ff);
		chk(48'(er), 48'h0000_0000_0001, "status write refused");
		rchk(12'h0123, 32'h0000_0000, 1'b1, "unmapped");
		$display("test registers done");
		xfer(1'b1, RHM_IDX_LOOP_CTRL, 32'h0010_0100);
		edge_diff(16'h0010, 16'h0011);
		rchk(RHM_IDX_LOOP_STATUS, 32'h0000_0002, 1'b0, "phase lock only");
		edge_diff(16'h0011, 16'h0010);
		rchk(RHM_IDX_LOOP_STATUS, 32'h0000_0001, 1'b0, "freq lock only");
		edge_diff(16'h0000, 16'h0000);
		for (int i = 0; i < 5; i++) begin
			stv <= 5'h01 << i;
			repeat (2) @(posedge ref_clk_i);
			xp = 3 | (4 << i);
			rchk(RHM_IDX_LOOP_STATUS, 32'(xp), 1'b0, "status");
		end
		stv <= '0;
		$display("test status done");
		// rows of prescaler and timer field; slack covers the registered fault path
		for (int r = 0; r < 3; r++) begin
			xfer(1'b1, RHM_IDX_LOOP_CTRL, 32'h0010_0100 | 32'(r / 2));
			xfer(1'b1, RHM_IDX_VALID_TIME, 32'(r == 1 ? 2 : r / 2));
			xp = ((2 << (r == 1 ? 2 : r / 2)) - 1) << (r / 2);
			la <= 1'b1;
			ob <= 1'b1;
			repeat (3) @(posedge ref_clk_i);
			chk(48'({va, vb}), 48'h0000_0000_0000, "withheld");
			la <= 1'b0;
			ob <= 1'b0;
			k = 0;
			do begin
				@(posedge ref_clk_i);
				k++;
			end while (va !== 1'b1 && k < 300);
			total_checks++;
			if (k < xp || k > xp + (2 << (r / 2)) + 2) begin
				n_fail++;
				$display("wrong value at %0t: validation took %0d expected %0d", $time, k, xp);
			end
			rchk(RHM_IDX_REF_STATE, 32'h0001_0003, 1'b0, "both valid");
		end
		$display("test validation done");
		xfer(1'b1, RHM_IDX_LOOP_CTRL, 32'h0010_0100);
		xfer(1'b1, RHM_IDX_REF_STATE, 32'h0003_0000);
		n0 = nev;
		k = nevb;
		repeat (9) begin
			ea <= 1'b1;
			eb <= 1'b1;
			@(posedge ref_clk_i);
			ea <= 1'b0;
			eb <= 1'b0;
			@(posedge ref_clk_i);
		end
		repeat (4) @(posedge ref_clk_i);
		chk(48'(nev - n0), 48'h0000_0000_0003, "evaluation ticks");
		chk(48'(nevb - k), 48'h0000_0000_0003, "evaluation ticks b");
		$display("test evaluation done");
		ftw <= 48'h1234_5678_9abc;
		repeat (4) @(posedge ref_clk_i);
		stv <= 5'h01;
		repeat (3) @(posedge ref_clk_i);
		ftw <= 48'h0000_0000_0001;
		repeat (5) @(posedge ref_clk_i);
		chk(hftw, 48'h1234_5678_9abc, "last word");
		// phase lock bit masked: it may read set while in holdover
		xfer(1'b0, RHM_IDX_LOOP_STATUS, 32'h0000_0000);
		chk(48'(rd & 32'h0000_00fd), 48'h0000_0000_0005, "holdover status");
		stv <= '0;
		xfer(1'b1, RHM_IDX_AUTO_CTRL, 32'h0000_0010);
		xfer(1'b1, RHM_IDX_AVG_WINDOW, 32'h0000_0002);
		// alternating words: only a mean over an even sample count lands between them
		for (int j = 0; j < 40; j++) begin
			ftw <= j[0] ? 48'h0000_0000_0fa2 : 48'h0000_0000_0fa0;
			stv <= (j == 37) ? 5'h01 : stv;
			@(posedge ref_clk_i);
		end
		ftw <= 48'h0000_0000_0001;
		repeat (6) @(posedge ref_clk_i);
		chk(hftw, 48'h0000_0000_0fa1, "averaged word");
		$display("test holdover done");
		finish_test();
	end
endmodule
`default_nettype wire
